// File: src/aar_reporter.sv
// per-port asynchronous alert framer, queue, retransmit timer and reply check
`timescale 1ns/1ps
module aar_reporter
   import aar_pkg::*;
#(
   parameter int RETX_CYC = AAR_RETX_CYC
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic node_reset,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic cap_start,
   input wire logic cap_vld,
   input wire logic [7:0] cap_byte,
   input wire logic ev_vld,
   input wire aar_event_t ev,
   output logic ev_rdy,
   input wire logic rep_vld,
   input wire aar_reply_t rep,
   output logic tx_vld,
   output logic [7:0] tx_byte,
   output logic tx_last,
   input wire logic tx_rdy,
   output logic priv_mode
);
   // ------------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------------
   function automatic logic ty_in(input logic [7:0] t, input logic [7:0] lo,
                                  input logic [7:0] hi);
      ty_in = (t >= lo) && (t <= hi);
   endfunction

   // frame context carries meaning only for these types
   function automatic logic ctx_valid(input logic [7:0] t);
      ctx_valid = (t == AAR_TY_UNK) || (t == AAR_TY_INV) || (t == AAR_TY_PROT);
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   aar_state_t st_q;
   logic [15:0] tag_q;
   logic [7:0] port_q;
   logic egress_q;
   logic [31:0] path_q;
   logic [2:0] plen_q;
   logic [7:0] last_rc_q;
   logic priv_q;
   logic [7:0] cap_q [AAR_FD_MAX];
   logic [4:0] cap_n_q;
   aar_entry_t q_mem [AAR_QDEPTH];
   logic [1:0] hd_q;
   logic [1:0] tl_q;
   logic [2:0] cnt_q;
   logic [5:0] idx_q;
   logic [26:0] tmr_q;
   logic [7:0] dbyte_q;
   logic dlast_q;
   logic [31:0] rdata_q;

   aar_entry_t head;
   logic accept;
   logic push;
   logic pop;
   logic timeout;
   logic is_erp;
   logic [5:0] msg_len;
   logic [AAR_FD_MAX*8-1:0] cap_flat;

   assign head = q_mem[hd_q];
   assign is_erp = ty_in(ev.code[23:16], AAR_TY_ERP_LO, AAR_TY_ERP_HI);
   // erp exits leaving via the failing port are dropped, master codes never sent
   assign accept = !(is_erp && ev.fail_port == egress_q)
                   && !ty_in(ev.code[23:16], AAR_TY_MST_LO, AAR_TY_MST_HI);
   assign ev_rdy = (cnt_q != 3'(AAR_QDEPTH));
   assign push = clk_en && ev_vld && ev_rdy && accept;
   // only a reply for the pending alert with tag and code matching the head pops
   assign pop = clk_en && rep_vld && st_q == AAR_WAIT && rep.tag == tag_q
                && rep.code == head.code;
   assign timeout = (tmr_q == 27'(RETX_CYC - 1));
   assign msg_len = 6'(plen_q) + 6'(AAR_HDR_LEN)
                    + (ctx_valid(head.code[23:16]) ? 6'(head.dlen) : 6'h00);

   // flatten the capture buffer, byte 0 in the low lane
   always_comb begin
      cap_flat = '0;
      for (int i = 0; i < AAR_FD_MAX; i++) begin
         cap_flat[i*8 +: 8] = cap_q[i];
      end
   end

   // ------------------------------------------------------------------
   // register port
   // ------------------------------------------------------------------
   // configuration written by software
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tag_q <= AAR_TAG_RST;
         port_q <= '0;
         egress_q <= 1'b0;
         path_q <= '0;
         plen_q <= AAR_PLEN_RST;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == AAR_REG_CFG) begin
            tag_q <= reg_wdata[15:0];
            port_q <= reg_wdata[23:16];
            egress_q <= reg_wdata[24];
         end
         if (reg_addr == AAR_REG_PATH) begin
            path_q <= reg_wdata;
         end
         if (reg_addr == AAR_REG_PLEN) begin
            plen_q <= (reg_wdata[2:0] > 3'h4) ? 3'h4 : reg_wdata[2:0];
         end
      end
   end

   // read data one cycle after the strobe, zero for unmapped offsets
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= '0;
      end else if (clk_en) begin
         rdata_q <= '0;
         if (reg_rd) begin
            unique case (reg_addr)
               AAR_REG_CFG: rdata_q <= {7'h00, egress_q, port_q, tag_q};
               AAR_REG_PATH: rdata_q <= path_q;
               AAR_REG_PLEN: rdata_q <= {29'h0, plen_q};
               AAR_REG_STAT: rdata_q <= {16'h0, last_rc_q, 3'b000, priv_q,
                                         cnt_q, st_q == AAR_WAIT};
               default: rdata_q <= '0;
            endcase
         end
      end
   end
   assign reg_rdata = rdata_q;

   // last return code from a matched reply
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         last_rc_q <= AAR_RC_OK;
      end else if (pop) begin
         last_rc_q <= rep.rc;
      end
   end

   // privileged mode: an operation, address or erp alert sets it (wins over clear), software clears it
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         priv_q <= 1'b0;
      end else if (clk_en) begin
         if (push && (ev.code[23:16] == AAR_TY_OPER || ev.code[23:16] == AAR_TY_ADDR
                      || is_erp)) begin
            priv_q <= 1'b1;
         end else if (reg_wr && reg_addr == AAR_REG_STAT && reg_wdata[0]) begin
            priv_q <= 1'b0;
         end
      end
   end
   assign priv_mode = priv_q;

   // ------------------------------------------------------------------
   // causing frame capture
   // ------------------------------------------------------------------
   // keeps the leading data bytes of the latest received frame
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cap_n_q <= '0;
         for (int i = 0; i < AAR_FD_MAX; i++) begin
            cap_q[i] <= '0;
         end
      end else if (clk_en) begin
         if (cap_start) begin
            cap_n_q <= '0;
         end else if (cap_vld && cap_n_q < 5'(AAR_FD_MAX)) begin
            cap_q[cap_n_q] <= cap_byte;
            cap_n_q <= cap_n_q + 5'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // alert queue
   // ------------------------------------------------------------------
   // entries wait here while one alert is outstanding
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < AAR_QDEPTH; i++) begin
            q_mem[i] <= '0;
         end
      end else if (push) begin
         q_mem[tl_q].code <= ev.code;
         q_mem[tl_q].ctrl <= ev.ctrl;
         q_mem[tl_q].chan <= ev.chan;
         q_mem[tl_q].dlen <= cap_n_q;
         q_mem[tl_q].data <= cap_flat;
      end
   end

   // pointers and occupancy, cleared by node reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hd_q <= '0;
         tl_q <= '0;
         cnt_q <= '0;
      end else if (clk_en) begin
         if (node_reset) begin
            hd_q <= '0;
            tl_q <= '0;
            cnt_q <= '0;
         end else begin
            if (push) begin
               tl_q <= tl_q + 2'h1;
            end
            if (pop) begin
               hd_q <= hd_q + 2'h1;
            end
            cnt_q <= cnt_q + 3'(push) - 3'(pop);
         end
      end
   end

   // ------------------------------------------------------------------
   // de-queue and retransmit control
   // ------------------------------------------------------------------
   // idle -> send -> wait; timeout in wait goes back to send
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_q <= AAR_IDLE;
      end else if (clk_en) begin
         if (node_reset) begin
            st_q <= AAR_IDLE;
         end else begin
            unique case (st_q)
               AAR_IDLE: if (cnt_q != 3'h0) st_q <= AAR_SEND;
               AAR_SEND: if (tx_rdy && dlast_q) st_q <= AAR_WAIT;
               AAR_WAIT: begin
                  if (pop) begin
                     st_q <= AAR_IDLE;
                  end else if (timeout) begin
                     st_q <= AAR_SEND;
                  end
               end
               default: st_q <= AAR_IDLE;
            endcase
         end
      end
   end

   // retransmit timer counts only while waiting
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tmr_q <= '0;
      end else if (clk_en) begin
         if (node_reset || st_q != AAR_WAIT || timeout) begin
            tmr_q <= '0;
         end else begin
            tmr_q <= tmr_q + 27'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // message serialiser
   // ------------------------------------------------------------------
   // byte at position i: path bytes, then the alert message
   function automatic logic [7:0] msg_byte(input logic [5:0] i);
      logic [5:0] j;
      logic fv;
      j = i - 6'(plen_q);
      fv = ctx_valid(head.code[23:16]);
      if (i < 6'(plen_q)) begin
         msg_byte = path_q[8*(3 - 32'(i)) +: 8];
      end else begin
         unique case (j)
            6'd0: msg_byte = AAR_MSG_ALERT;
            6'd1: msg_byte = port_q;
            6'd2: msg_byte = tag_q[15:8];
            6'd3: msg_byte = tag_q[7:0];
            6'd4: msg_byte = head.code[23:16];
            6'd5: msg_byte = head.code[15:8];
            6'd6: msg_byte = head.code[7:0];
            6'd7: msg_byte = 8'h00;
            6'd8: msg_byte = fv ? head.ctrl : 8'h00;
            6'd9: msg_byte = fv ? head.chan[15:8] : 8'h00;
            6'd10: msg_byte = fv ? head.chan[7:0] : 8'h00;
            default: msg_byte = head.data[8*(32'(j) - AAR_HDR_LEN) +: 8];
         endcase
      end
   endfunction

   // index and registered byte; restart from byte 0 on each launch
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         idx_q <= '0;
         dbyte_q <= '0;
         dlast_q <= 1'b0;
      end else if (clk_en) begin
         if (st_q != AAR_SEND || (tx_rdy && dlast_q)) begin
            idx_q <= 6'h01;
            dbyte_q <= msg_byte(6'h00);
            dlast_q <= 1'b0;
         end else if (tx_rdy) begin
            idx_q <= idx_q + 6'h01;
            dbyte_q <= msg_byte(idx_q);
            dlast_q <= (idx_q == msg_len - 6'h01);
         end
      end
   end
   assign tx_vld = (st_q == AAR_SEND) && !node_reset;
   assign tx_byte = dbyte_q;
   assign tx_last = dlast_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_erp_same_drop: assert property (@(posedge clock) disable iff (!rstn)
      (clk_en && ev_vld && ev_rdy && is_erp && ev.fail_port == egress_q && !node_reset)
      |=> cnt_q == $past(cnt_q) - 3'($past(pop)))
      else $error("erp alert via failing port was queued");

   a_master_code_drop: assert property (@(posedge clock) disable iff (!rstn)
      push |-> !ty_in(ev.code[23:16], AAR_TY_MST_LO, AAR_TY_MST_HI))
      else $error("master generated alert code queued");

   a_pending_held: assert property (@(posedge clock) disable iff (!rstn)
      (st_q == AAR_WAIT && !pop && !timeout && !node_reset) |=> st_q == AAR_WAIT)
      else $error("pending alert left without reply");

   a_retx_after_timeout: assert property (@(posedge clock) disable iff (!rstn)
      (clk_en && st_q == AAR_WAIT && timeout && !pop && !node_reset)
      |=> st_q == AAR_SEND && tmr_q == 27'h0)
      else $error("no retransmission after timeout");

   a_tag_mismatch_ign: assert property (@(posedge clock) disable iff (!rstn)
      (rep_vld && rep.tag != tag_q) |-> !pop)
      else $error("reply with wrong tag accepted");

   a_idle_reply_drop: assert property (@(posedge clock) disable iff (!rstn)
      (clk_en && rep_vld && st_q != AAR_WAIT && !push && !node_reset)
      |=> cnt_q == $past(cnt_q))
      else $error("reply without pending alert changed queue");

   a_reset_clears: assert property (@(posedge clock) disable iff (!rstn)
      (clk_en && node_reset) |=> st_q == AAR_IDLE && cnt_q == 3'h0 && tmr_q == 27'h0)
      else $error("node reset did not clear alert state");

   a_first_byte_code: assert property (@(posedge clock) disable iff (!rstn)
      (clk_en && st_q == AAR_SEND && tx_rdy && idx_q == 6'(plen_q))
      |=> tx_byte == AAR_MSG_ALERT)
      else $error("alert message code byte wrong");

   a_launch_needs_entry: assert property (@(posedge clock) disable iff (!rstn)
      ($rose(st_q == AAR_SEND) && $past(st_q) == AAR_IDLE) |-> $past(cnt_q) != 3'h0)
      else $error("alert launched with empty queue");

   a_addr_err_priv: assert property (@(posedge clock) disable iff (!rstn)
      (push && ev.code == AAR_CODE_ADDR_ERR) |=> priv_q)
      else $error("address error did not set privileged mode");

   a_too_much_keep: assert property (@(posedge clock) disable iff (!rstn)
      (push && ev.code == AAR_CODE_TOO_MUCH && !(reg_wr && reg_addr == AAR_REG_STAT))
      |=> priv_q == $past(priv_q))
      else $error("too much data changed port mode");

   a_fail_pred_keep: assert property (@(posedge clock) disable iff (!rstn)
      (push && ev.code[23:8] == AAR_CODE_FAIL_PRED && !(reg_wr && reg_addr == AAR_REG_STAT))
      |=> priv_q == $past(priv_q))
      else $error("failure prediction changed port mode");
endmodule // aar_reporter

// File: src/aar_pkg.sv
// package for the asynchronous alert reporter: constants and types
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package aar_pkg;
   // message codes and field values
   localparam logic [7:0] AAR_MSG_ALERT = 8'h04;
   localparam logic [7:0] AAR_MSG_REPLY = 8'h07;
   localparam logic [7:0] AAR_RC_OK = 8'h00;
   localparam logic [7:0] AAR_RC_BAD = 8'hFF;
   localparam logic [7:0] AAR_TY_OPER = 8'h00;
   localparam logic [7:0] AAR_TY_ADDR = 8'h01;
   localparam logic [7:0] AAR_TY_UNK = 8'h02;
   localparam logic [7:0] AAR_TY_INV = 8'h03;
   localparam logic [7:0] AAR_TY_PROT = 8'h04;
   localparam logic [7:0] AAR_TY_WARN = 8'h06;
   localparam logic [7:0] AAR_TY_ERP_LO = 8'h10;
   localparam logic [7:0] AAR_TY_ERP_HI = 8'h19;
   localparam logic [7:0] AAR_TY_MST_LO = 8'hBC;
   localparam logic [7:0] AAR_TY_MST_HI = 8'hC0;
   localparam logic [23:0] AAR_CODE_ADDR_ERR = 24'h01_0100;
   localparam logic [23:0] AAR_CODE_TOO_MUCH = 24'h04_0400;
   localparam logic [15:0] AAR_CODE_FAIL_PRED = 16'h0602;
   // frame data and queue sizing
   localparam int AAR_FD_MAX = 21;
   localparam int AAR_QDEPTH = 4;
   localparam int AAR_HDR_LEN = 11;
   // retransmission time
   localparam int AAR_CLK_MHZ = 250;
   localparam int AAR_RETX_MS = 500;
   localparam int AAR_RETX_CYC = AAR_RETX_MS * 1000 * AAR_CLK_MHZ;
   // register offsets
   localparam logic [7:0] AAR_REG_CFG = 8'h00;
   localparam logic [7:0] AAR_REG_PATH = 8'h04;
   localparam logic [7:0] AAR_REG_PLEN = 8'h08;
   localparam logic [7:0] AAR_REG_STAT = 8'h0C;
   // reset values
   localparam logic [15:0] AAR_TAG_RST = 16'h0000;
   localparam logic [2:0] AAR_PLEN_RST = 3'h4;

   // alert event from the port logic
   typedef struct packed {
      logic [23:0] code;
      logic [7:0] ctrl;
      logic [15:0] chan;
      logic fail_port;
   } aar_event_t;

   // decoded reply from the master
   typedef struct packed {
      logic [7:0] rc;
      logic [15:0] tag;
      logic [23:0] code;
   } aar_reply_t;

   // queued alert entry
   typedef struct packed {
      logic [23:0] code;
      logic [7:0] ctrl;
      logic [15:0] chan;
      logic [4:0] dlen;
      logic [AAR_FD_MAX*8-1:0] data;
   } aar_entry_t;

   typedef enum logic [1:0] {
      AAR_IDLE = 2'b00,
      AAR_SEND = 2'b01,
      AAR_WAIT = 2'b11
   } aar_state_t;
endpackage

// File: verif/aar_master_model.sv
// master node model: takes alert bytes with stalls and replies to each one
`timescale 1ns/1ps
module aar_master_model
   import aar_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic tx_vld,
   input wire logic [7:0] tx_byte,
   input wire logic tx_last,
   output logic tx_rdy,
   output logic rep_vld,
   output aar_reply_t rep,
   input wire logic reply_en,
   input wire logic bad_tag,
   input wire logic [2:0] plen
);
   logic [7:0] msg_q [0:63];
   logic [5:0] n_q;
   logic [2:0] dly_q;
   logic [15:0] lfsr_q;
   int p;
   assign p = (plen > 3'd4) ? 4 : int'(plen);
   // ------------------------------------------------------------
   // byte intake and reply launch
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         n_q <= '0;
         dly_q <= '0;
         lfsr_q <= 16'h00a5;
         tx_rdy <= 1'b0;
         rep_vld <= 1'b0;
         rep <= '0;
      end else begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
         tx_rdy <= lfsr_q[0] | lfsr_q[4]; // stalls about one cycle in four
         rep_vld <= (dly_q == 3'd1);
         if (tx_vld && tx_rdy) begin
            msg_q[n_q] <= tx_byte;
            n_q <= tx_last ? 6'd0 : n_q + 6'd1;
         end
         if (tx_vld && tx_rdy && tx_last && reply_en) begin
            dly_q <= 3'd4; // each copy gets a reply
         end else if (dly_q != 3'd0) begin
            dly_q <= dly_q - 3'd1;
         end
         if (dly_q == 3'd1) begin
            rep.rc <= AAR_RC_OK;
            rep.tag <= {msg_q[p+2], msg_q[p+3]} ^ {15'h0, bad_tag};
            rep.code <= {msg_q[p+4], msg_q[p+5], msg_q[p+6]};
         end else begin
            rep <= ~rep; // contents inverted every cycle between replies
         end
      end
   end
endmodule // aar_master_model

// File: verif/tb_aar_reporter.sv
// self-checking bench for the alert reporter against a master model
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_aar_reporter
   import aar_pkg::*;
;
   logic clock = 0, rstn = 0, node_reset = 0, reg_wr = 0, reg_rd = 0;
   logic cap_start = 0, cap_vld = 0, ev_vld = 0, reply_en = 1, bad_tag = 0, clk_en = 1;
   logic [7:0] reg_addr = '0, cap_byte = '0, port, tx_byte;
   logic [31:0] reg_wdata = '0, reg_rdata, path, v, seed = 32'h0000_9d28;
   logic ev_rdy, rep_vld, tx_vld, tx_rdy, tx_last, priv_mode;
   logic [2:0] plen = 3'd4;
   logic [15:0] tag;
   logic [7:0] fd [0:20];
   logic [7:0] got [$];
   logic [7:0] exq [$];
   logic [23:0] codes [5] = '{24'h02_0100, 24'h03_0200, 24'h04_0100, 24'h05_0200, 24'h06_0200};
   aar_event_t ev = '0;
   aar_event_t evq [$];
   aar_reply_t rep;
   int failures = 0, num_checks = 0, msgs = 0, nm = 0, cyc = 0, dlen = 0;
   aar_reporter #(.RETX_CYC(50)) u_aar_reporter (.clock(clock), .rstn(rstn), .clk_en(clk_en),
      .node_reset(node_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_start(cap_start), .cap_vld(cap_vld),
      .cap_byte(cap_byte), .ev_vld(ev_vld), .ev(ev), .ev_rdy(ev_rdy), .rep_vld(rep_vld),
      .rep(rep), .tx_vld(tx_vld), .tx_byte(tx_byte), .tx_last(tx_last), .tx_rdy(tx_rdy),
      .priv_mode(priv_mode));
   aar_master_model u_aar_master_model (.clock(clock), .rstn(rstn), .tx_vld(tx_vld),
      .tx_byte(tx_byte), .tx_last(tx_last), .tx_rdy(tx_rdy), .rep_vld(rep_vld), .rep(rep),
      .reply_en(reply_en), .bad_tag(bad_tag), .plen(plen));
   always #2 clock = ~clock;
   // collect every accepted message byte
   always @(posedge clock) begin
      if (rstn && tx_vld && tx_rdy) begin
         got.push_back(tx_byte);
         if (tx_last) msgs++;
      end
   end
   // cut a hung run short
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         give_verdict();
      end
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic give_verdict();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic cap_frame(input int n);
      @(posedge clock);
      cap_start <= 1'b1;
      @(posedge clock);
      cap_start <= 1'b0;
      for (int i = 0; i < n; i++) begin
         cap_vld <= 1'b1;
         cap_byte <= 8'(rnd());
         if (i < 21) fd[i] = 8'(seed);
         @(posedge clock);
      end
      cap_vld <= 1'b0;
      dlen = (n > 21) ? 21 : n;
   endtask
   task automatic send_ev(input logic [23:0] c, input logic fp, input logic keep);
      aar_event_t e;
      e = '{code: c, ctrl: 8'(rnd()), chan: 16'(rnd()), fail_port: fp};
      @(posedge clock);
      ev_vld <= 1'b1;
      ev <= e;
      if (keep) evq.push_back(e);
      do @(posedge clock); while (!ev_rdy);
      ev_vld <= 1'b0;
   endtask
   task automatic wait_msg();
      nm++;
      for (int i = 0; i < 400 && msgs < nm; i++) @(posedge clock);
      `CHK(msgs >= nm, 1'b1)
   endtask
   task automatic chk_msg(input bit pop);
      aar_event_t e;
      logic [7:0] a, b;
      e = evq[0];
      if (pop) void'(evq.pop_front());
      exq = {};
      for (int i = 0; i < plen; i++) exq.push_back(path[31-8*i -: 8]);
      exq = {exq, 8'h04, port, tag[15:8], tag[7:0], e.code[23:16], e.code[15:8], e.code[7:0]};
      exq.push_back(8'h00);
      if (e.code[23:16] inside {8'h02, 8'h03, 8'h04}) begin
         exq = {exq, e.ctrl, e.chan[15:8], e.chan[7:0]};
         for (int i = 0; i < dlen; i++) exq.push_back(fd[i]);
      end else exq = {exq, 8'h00, 8'h00, 8'h00};
      `CHK(got.size() >= exq.size(), 1'b1)
      while (exq.size() > 0 && got.size() > 0) begin
         a = got.pop_front();
         b = exq.pop_front();
         `CHK(a, b)
      end
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      rd(8'h08);
      `CHK(v[2:0], 3'h4)
      tag = 16'(rnd());
      port = 8'(rnd());
      path = rnd();
      plen = 3'd3;
      wr(8'h00, {8'h00, port, tag});
      wr(8'h04, path);
      wr(8'h08, 32'h0000_0003);
      wr(8'h30, 32'hffff_ffff);
      rd(8'h30);
      `CHK(v, 32'h0000_0000)
      rd(8'h00);
      `CHK(v[23:0], {port, tag})
      cap_frame(25);
      send_ev(24'h04_0400, 1'b0, 1'b1);
      wait_msg();
      chk_msg(1);
      `CHK(priv_mode, 1'b0)
      repeat (12) @(posedge clock);
      rd(8'h0C);
      `CHK(v[15:0], 16'h0000)
      for (int i = 0; i < 5; i++) begin
         cap_frame(17 + i);
         send_ev(codes[i] | 24'(i == 4 ? 8'(rnd()) : 8'h00), 1'b0, 1'b1);
         wait_msg();
         chk_msg(1);
         repeat (12) @(posedge clock);
      end
      `CHK(priv_mode, 1'b0)
      send_ev(24'h01_0100, 1'b0, 1'b1);
      wait_msg();
      chk_msg(1);
      `CHK(priv_mode, 1'b1)
      repeat (12) @(posedge clock);
      wr(8'h0C, 32'h0000_0001);
      send_ev({8'h14, 16'(rnd())}, 1'b0, 1'b0);
      send_ev(24'hBC_0000, 1'b0, 1'b0);
      send_ev(24'hC0_0100, 1'b1, 1'b0);
      send_ev({8'h16, 16'(rnd())}, 1'b1, 1'b1);
      wait_msg();
      chk_msg(1);
      `CHK(priv_mode, 1'b1)
      repeat (12) @(posedge clock);
      reply_en <= 1'b0;
      send_ev(24'h05_0100, 1'b0, 1'b1);
      wait_msg();
      chk_msg(0);
      repeat (45) @(posedge clock);
      `CHK(msgs, nm)
      wait_msg();
      chk_msg(0);
      bad_tag <= 1'b1;
      reply_en <= 1'b1;
      wait_msg();
      chk_msg(0);
      repeat (10) @(posedge clock);
      rd(8'h0C);
      `CHK(v[0], 1'b1)
      bad_tag <= 1'b0;
      wait_msg();
      chk_msg(1);
      repeat (10) @(posedge clock);
      rd(8'h0C);
      `CHK(v[3:0], 4'h0)
      reply_en <= 1'b0;
      for (int i = 0; i < 4; i++) send_ev(24'h05_0100 + 24'(i), 1'b0, 1'b1);
      #1 `CHK(ev_rdy, 1'b0)
      wait_msg();
      chk_msg(1);
      repeat (20) @(posedge clock);
      `CHK(msgs, nm)
      rd(8'h0C);
      `CHK(v[3:0], 4'h9)
      @(posedge clock);
      node_reset <= 1'b1;
      @(posedge clock);
      node_reset <= 1'b0;
      rd(8'h0C);
      `CHK(v[3:0], 4'h0)
      repeat (150) @(posedge clock);
      `CHK(msgs, nm)
      evq = {};
      reply_en <= 1'b1;
      send_ev(24'h05_0200, 1'b0, 1'b1);
      wait_msg();
      chk_msg(1);
      node_reset <= 1'b1;
      @(posedge clock);
      node_reset <= 1'b0;
      repeat (10) @(posedge clock);
      rd(8'h0C);
      `CHK(v[3:0], 4'h0)
      // a write while the clock enable is low must not land
      clk_en <= 1'b0;
      wr(8'h08, 32'h0000_0001);
      clk_en <= 1'b1;
      rd(8'h08);
      `CHK(v[2:0], 3'h3)
      give_verdict();
   end
endmodule // tb_aar_reporter
